/* File: pss_pkg.sv */
// constants, state encoding and timing figures for the power state sequencer
// assumes a 10 MHz system clock and a 32.768 kHz crystal sampled on that clock
package pss_pkg;
  localparam int MCLK_HZ = 10_000_000;
  localparam int XTAL_HZ = 32768;
  localparam int OSC_TOL_PCT = 10;
  localparam int OSC_NOM_CYC = MCLK_HZ / XTAL_HZ;
  localparam int OSC_MIN_CYC = OSC_NOM_CYC * (100 - OSC_TOL_PCT) / 100;
  localparam int OSC_MAX_CYC = OSC_NOM_CYC * (100 + OSC_TOL_PCT) / 100;
  localparam int OSC_CNT_W = 10;
  localparam int READY_TIME_MS = 15;
  localparam int READY_CYC = READY_TIME_MS * (MCLK_HZ / 1000);
  localparam int CLK_START_MS = 50;
  localparam int CLK_START_CYC = CLK_START_MS * (MCLK_HZ / 1000);
  localparam int SLOT_TIME_US = 100;
  localparam int SLOT_CYC = SLOT_TIME_US * (MCLK_HZ / 1_000_000);
  localparam int RST_UNIT_US = 1000;
  localparam int RST_UNIT_CYC = RST_UNIT_US * (MCLK_HZ / 1_000_000);
  localparam int CFG_W = 8;
  localparam int CODE_W = 13;
  localparam int SYN_W = 4;
  localparam int FIELD_W = 2;
  localparam logic [FIELD_W-1:0] FIELD_NONE = 2'h0;
  localparam int FLT_W = 3;
  localparam int FLT_SELFTEST = 0;
  localparam int FLT_DED = 1;
  localparam int FLT_OSC = 2;
  typedef enum logic [3:0] {
    ST_OFF, ST_SELFTEST, ST_LOAD, ST_SHUTDOWN_STATE_ONE, ST_SHUTDOWN_STATE_TWO, ST_PWRUP, ST_RSTDLY,
    ST_ACTIVE, ST_SLEEP, ST_PWRDN, ST_BACKUP, ST_FAILSAFE
  } pss_state_e;
endpackage

/* File: pss_top.sv */
// power state sequencer: power states, slot sequencing, config load, clock monitor
// assumes all inputs synchronous to mclk_i; resetn_i is the power-on reset
`timescale 1ns/1ps
module pss_top #(
  parameter int N_RAILS = 12,
  parameter int SLOT_W = 4,
  parameter int TMR_W = 24,
  parameter int READY_CYC = pss_pkg::READY_CYC,
  parameter int CLK_START_CYC = pss_pkg::CLK_START_CYC,
  parameter int SLOT_CYC = pss_pkg::SLOT_CYC,
  parameter int RST_UNIT_CYC = pss_pkg::RST_UNIT_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic supply_valid_i,
  input wire logic battery_supply_ok_i,
  input wire logic selftest_done_i,
  input wire logic selftest_fail_i,
  input wire logic selftest_on_poweron_i,
  input wire logic selftest_on_shutdown_exit_i,
  input wire logic [pss_pkg::CODE_W-1:0] otp_word_i,
  input wire logic active_request_in_i,
  input wire logic sleep_request_n_i,
  input wire logic power_button_in_n_i,
  input wire logic button_enable_i,
  input wire logic [pss_pkg::FIELD_W-1:0] soft_shutdown_field_i,
  input wire logic [3:0] reset_release_delay_i,
  input wire logic [N_RAILS*SLOT_W-1:0] powerup_slot_select_i,
  input wire logic [N_RAILS-1:0] sleep_assign_i,
  input wire logic xtal_i,
  input wire logic [pss_pkg::FLT_W-1:0] fault_clear_i,
  input wire logic write_guard_one_set_i,
  input wire logic write_guard_two_set_i,
  output logic [N_RAILS-1:0] rail_enable_out_o,
  output logic system_reset_out_n_o,
  output logic interrupt_out_n_o,
  output logic rtc_clock_out_o,
  output logic i2c_active_o,
  output logic [pss_pkg::CFG_W-1:0] config_data_o,
  output logic ecc_corrected_o,
  output logic [pss_pkg::FLT_W-1:0] fault_status_o,
  output logic [31:0] rtc_time_o,
  output logic write_guard_one_o,
  output logic write_guard_two_o,
  output logic [3:0] power_state_o
);
  localparam logic [TMR_W-1:0] READY_T = TMR_W'(READY_CYC);
  localparam logic [TMR_W-1:0] SLOT_T = TMR_W'(SLOT_CYC);
  localparam logic [SLOT_W-1:0] FIRST_SLOT = SLOT_W'(1);
  localparam logic [SLOT_W-1:0] LAST_SLOT = '1;
  localparam logic [pss_pkg::OSC_CNT_W-1:0] OSC_MIN = pss_pkg::OSC_CNT_W'(pss_pkg::OSC_MIN_CYC);
  localparam logic [pss_pkg::OSC_CNT_W-1:0] OSC_MAX = pss_pkg::OSC_CNT_W'(pss_pkg::OSC_MAX_CYC);
  localparam logic [14:0] PRESCALE_TOP = 15'(pss_pkg::XTAL_HZ - 1);

  // ************************************************************
  // helper functions
  // ************************************************************
  // hamming code with overall parity in bit 0: {double error, single error, data}
  function automatic logic [pss_pkg::CFG_W+1:0] ecc_fix(input logic [pss_pkg::CODE_W-1:0] cw);
    logic [pss_pkg::SYN_W-1:0] syn;
    logic par;
    logic [pss_pkg::CODE_W-1:0] c;
    logic [pss_pkg::CFG_W-1:0] d;
    int k;
    syn = '0;
    par = ^cw;
    c = cw;
    d = '0;
    k = 0;
    for (int i = 1; i < pss_pkg::CODE_W; i++) begin
      if (cw[i]) syn = syn ^ pss_pkg::SYN_W'(i);
    end
    if (par && syn != '0 && int'(syn) < pss_pkg::CODE_W) c[syn] = ~c[syn];
    for (int i = 1; i < pss_pkg::CODE_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = c[i];
        k++;
      end
    end
    return {~par && syn != '0, par, d};
  endfunction

  // rails whose slot is assigned and not later than the limit
  function automatic logic [N_RAILS-1:0] rails_upto(input logic [N_RAILS*SLOT_W-1:0] sel,
                                                    input logic [SLOT_W-1:0] lim);
    logic [N_RAILS-1:0] m;
    m = '0;
    for (int r = 0; r < N_RAILS; r++) begin
      m[r] = sel[r*SLOT_W +: SLOT_W] != '0 && sel[r*SLOT_W +: SLOT_W] <= lim;
    end
    return m;
  endfunction

  // ************************************************************
  // state machine
  // ************************************************************
  pss_pkg::pss_state_e state_reg, state_next;
  logic [SLOT_W-1:0] slot_reg, slot_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [pss_pkg::FIELD_W-1:0] field_reg, field_next;
  logic cfg_loaded_reg;
  logic strap_reg;
  logic [pss_pkg::CFG_W+1:0] ecc_res;
  logic supplied, supply_lost, start_one, start_two, stop_req, slot_done, clk_run;
  logic [TMR_W-1:0] rst_target;

  assign ecc_res = ecc_fix(otp_word_i);
  assign supplied = state_reg != pss_pkg::ST_OFF && state_reg != pss_pkg::ST_BACKUP;
  assign supply_lost = supplied && !supply_valid_i;
  assign slot_done = tmr_reg == SLOT_T - TMR_W'(1);
  assign rst_target = TMR_W'(32'(reset_release_delay_i) * 32'(RST_UNIT_CYC));
  assign start_one = button_enable_i ? (!strap_reg || !power_button_in_n_i)
                                     : active_request_in_i;
  assign start_two = button_enable_i ? !power_button_in_n_i : active_request_in_i;
  assign stop_req = soft_shutdown_field_i != pss_pkg::FIELD_NONE
                    || (!button_enable_i && !active_request_in_i);

  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    field_next = field_reg;
    tmr_next = tmr_reg + TMR_W'(1);
    unique case (state_reg)
      pss_pkg::ST_OFF: begin
        if (supply_valid_i) begin
          state_next = selftest_on_poweron_i ? pss_pkg::ST_SELFTEST : pss_pkg::ST_LOAD;
        end
      end
      pss_pkg::ST_SELFTEST: begin
        if (selftest_fail_i || tmr_reg == READY_T - TMR_W'(1)) begin
          state_next = pss_pkg::ST_FAILSAFE;
        end else if (selftest_done_i) begin
          state_next = pss_pkg::ST_LOAD;
        end
      end
      pss_pkg::ST_LOAD: begin
        state_next = ecc_res[pss_pkg::CFG_W+1] ? pss_pkg::ST_FAILSAFE : pss_pkg::ST_SHUTDOWN_STATE_ONE;
      end
      pss_pkg::ST_SHUTDOWN_STATE_ONE, pss_pkg::ST_SHUTDOWN_STATE_TWO: begin
        if (state_reg == pss_pkg::ST_SHUTDOWN_STATE_ONE ? start_one : start_two) begin
          state_next = pss_pkg::ST_PWRUP;
          slot_next = FIRST_SLOT;
        end
      end
      pss_pkg::ST_PWRUP: begin
        if (slot_done) begin
          tmr_next = '0;
          if (slot_reg == LAST_SLOT) state_next = pss_pkg::ST_RSTDLY;
          else slot_next = slot_reg + FIRST_SLOT;
        end
      end
      pss_pkg::ST_RSTDLY: begin
        if (tmr_reg >= rst_target) state_next = pss_pkg::ST_ACTIVE;
      end
      pss_pkg::ST_ACTIVE, pss_pkg::ST_SLEEP: begin
        if (stop_req) begin
          state_next = pss_pkg::ST_PWRDN;
          slot_next = LAST_SLOT;
          field_next = soft_shutdown_field_i;
        end else if (!sleep_request_n_i) begin
          state_next = pss_pkg::ST_SLEEP;
        end else begin
          state_next = pss_pkg::ST_ACTIVE;
        end
      end
      pss_pkg::ST_PWRDN: begin
        if (slot_done) begin
          tmr_next = '0;
          if (slot_reg != FIRST_SLOT) slot_next = slot_reg - FIRST_SLOT;
          else if (field_reg != pss_pkg::FIELD_NONE) state_next = pss_pkg::ST_SHUTDOWN_STATE_TWO;
          else if (selftest_on_shutdown_exit_i) state_next = pss_pkg::ST_SELFTEST;
          else state_next = pss_pkg::ST_SHUTDOWN_STATE_ONE;
        end
      end
      pss_pkg::ST_BACKUP: begin
        if (supply_valid_i) state_next = pss_pkg::ST_SHUTDOWN_STATE_ONE;
      end
      pss_pkg::ST_FAILSAFE: state_next = pss_pkg::ST_FAILSAFE;
    endcase
    if (supply_lost) begin
      // emergency power-down wins over every other transition
      state_next = (battery_supply_ok_i && cfg_loaded_reg) ? pss_pkg::ST_BACKUP
                                                           : pss_pkg::ST_OFF;
    end
    if (state_next != state_reg) tmr_next = '0;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_reg <= pss_pkg::ST_OFF;
      slot_reg <= '0;
      tmr_reg <= '0;
      field_reg <= pss_pkg::FIELD_NONE;
    end else begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      tmr_reg <= tmr_next;
      field_reg <= field_next;
    end
  end

  // ************************************************************
  // configuration load and strap
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cfg_loaded_reg <= 1'b0;
      config_data_o <= '0;
      ecc_corrected_o <= 1'b0;
      strap_reg <= 1'b0;
    end else if (state_reg == pss_pkg::ST_LOAD && !ecc_res[pss_pkg::CFG_W+1]) begin
      cfg_loaded_reg <= 1'b1;
      config_data_o <= ecc_res[pss_pkg::CFG_W-1:0];
      ecc_corrected_o <= ecc_res[pss_pkg::CFG_W];
      strap_reg <= active_request_in_i;
    end
  end

  // ************************************************************
  // pin outputs
  // ************************************************************
  assign clk_run = supplied && state_reg != pss_pkg::ST_SELFTEST
                   && state_reg != pss_pkg::ST_FAILSAFE;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rail_enable_out_o <= '0;
      system_reset_out_n_o <= 1'b0;
      interrupt_out_n_o <= 1'b1;
      rtc_clock_out_o <= 1'b0;
      i2c_active_o <= 1'b0;
    end else begin
      unique case (state_reg)
        pss_pkg::ST_PWRUP: rail_enable_out_o <= rails_upto(powerup_slot_select_i, slot_reg);
        pss_pkg::ST_RSTDLY, pss_pkg::ST_ACTIVE:
          rail_enable_out_o <= rails_upto(powerup_slot_select_i, LAST_SLOT);
        pss_pkg::ST_SLEEP: rail_enable_out_o <= rail_enable_out_o & ~sleep_assign_i;
        pss_pkg::ST_PWRDN: rail_enable_out_o <= rail_enable_out_o
            & rails_upto(powerup_slot_select_i, slot_reg - FIRST_SLOT);
        default: rail_enable_out_o <= '0;
      endcase
      system_reset_out_n_o <= state_reg == pss_pkg::ST_ACTIVE || state_reg == pss_pkg::ST_SLEEP;
      if (state_reg == pss_pkg::ST_FAILSAFE) interrupt_out_n_o <= 1'b0;
      else if (!supplied || state_reg == pss_pkg::ST_SELFTEST) interrupt_out_n_o <= 1'b1;
      else interrupt_out_n_o <= ~|fault_status_o;
      rtc_clock_out_o <= clk_run && xtal_i;
      i2c_active_o <= supplied && state_reg != pss_pkg::ST_SELFTEST;
    end
  end

  // ************************************************************
  // crystal monitor, rtc counter, fault status
  // ************************************************************
  logic xtal_q_reg, seen_reg, xtal_rise, osc_bad;
  logic [pss_pkg::OSC_CNT_W-1:0] per_reg;
  logic [14:0] prescale_reg;
  logic [pss_pkg::FLT_W-1:0] flt_set;

  assign xtal_rise = xtal_i && !xtal_q_reg;
  assign osc_bad = clk_run && ((xtal_rise && seen_reg
                   && per_reg < OSC_MIN - pss_pkg::OSC_CNT_W'(1))
                   || per_reg == OSC_MAX);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      xtal_q_reg <= 1'b0;
      seen_reg <= 1'b0;
      per_reg <= '0;
    end else begin
      xtal_q_reg <= xtal_i;
      if (!clk_run) begin
        seen_reg <= 1'b0;
        per_reg <= '0;
      end else if (xtal_rise) begin
        seen_reg <= 1'b1;
        per_reg <= '0;
      end else if (per_reg != OSC_MAX) begin
        per_reg <= per_reg + pss_pkg::OSC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      prescale_reg <= '0;
      rtc_time_o <= '0;
    end else if (state_reg != pss_pkg::ST_OFF && xtal_rise) begin
      prescale_reg <= (prescale_reg == PRESCALE_TOP) ? '0 : prescale_reg + 15'h1;
      if (prescale_reg == PRESCALE_TOP) rtc_time_o <= rtc_time_o + 32'h1;
    end
  end

  always_comb begin
    flt_set = '0;
    flt_set[pss_pkg::FLT_SELFTEST] = state_reg == pss_pkg::ST_SELFTEST
        && state_next == pss_pkg::ST_FAILSAFE;
    flt_set[pss_pkg::FLT_DED] = state_reg == pss_pkg::ST_LOAD && ecc_res[pss_pkg::CFG_W+1];
    flt_set[pss_pkg::FLT_OSC] = osc_bad;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      fault_status_o <= '0;
      write_guard_one_o <= 1'b0;
      write_guard_two_o <= 1'b0;
      power_state_o <= '0;
    end else begin
      fault_status_o <= (fault_status_o & ~fault_clear_i) | flt_set;
      if (state_next == pss_pkg::ST_BACKUP && state_reg != pss_pkg::ST_BACKUP) begin
        write_guard_one_o <= 1'b0;
        write_guard_two_o <= 1'b0;
      end else begin
        write_guard_one_o <= write_guard_one_o | write_guard_one_set_i;
        write_guard_two_o <= write_guard_two_o | write_guard_two_set_i;
      end
      power_state_o <= state_next;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  logic [TMR_W-1:0] up_reg;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || !supplied) up_reg <= '0;
    // counts only cycles without the clock: holds while the clock runs, resumes counting in a later shutdown self-test
    else if (up_reg != TMR_W'(CLK_START_CYC) && !clk_run) up_reg <= up_reg + TMR_W'(1);
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  property p_selftest_outs;
    state_reg == pss_pkg::ST_SELFTEST |=> rail_enable_out_o == '0 && !system_reset_out_n_o
      && interrupt_out_n_o && !rtc_clock_out_o && !i2c_active_o;
  endproperty
  a_selftest_outs: assert property (p_selftest_outs) else $error("self-test outputs wrong");
  property p_backup_outs;
    state_reg == pss_pkg::ST_BACKUP |=> rail_enable_out_o == '0 && !system_reset_out_n_o
      && !rtc_clock_out_o;
  endproperty
  a_backup_outs: assert property (p_backup_outs) else $error("backup outputs wrong");
  property p_failsafe_outs;
    state_reg == pss_pkg::ST_FAILSAFE |=> rail_enable_out_o == '0 && !system_reset_out_n_o
      && !interrupt_out_n_o && !rtc_clock_out_o;
  endproperty
  a_failsafe_outs: assert property (p_failsafe_outs) else $error("failsafe outputs wrong");
  property p_guard_clear;
    state_reg != pss_pkg::ST_BACKUP ##1 state_reg == pss_pkg::ST_BACKUP
      |-> !write_guard_one_o && !write_guard_two_o;
  endproperty
  a_guard_clear: assert property (p_guard_clear) else $error("guards kept in backup");
  property p_backup_exit;
    state_reg == pss_pkg::ST_BACKUP && supply_valid_i |=> state_reg == pss_pkg::ST_SHUTDOWN_STATE_ONE;
  endproperty
  a_backup_exit: assert property (p_backup_exit) else $error("backup exit wrong");
  property p_ded;
    state_reg == pss_pkg::ST_LOAD && supply_valid_i && ecc_res[pss_pkg::CFG_W+1]
      |=> state_reg == pss_pkg::ST_FAILSAFE ##1 !interrupt_out_n_o;
  endproperty
  a_ded: assert property (p_ded) else $error("double error not failsafe");
  property p_failsafe_hold;
    state_reg == pss_pkg::ST_FAILSAFE && supply_valid_i |=> state_reg == pss_pkg::ST_FAILSAFE;
  endproperty
  a_failsafe_hold: assert property (p_failsafe_hold) else $error("failsafe left");
  property p_emergency;
    state_reg == pss_pkg::ST_ACTIVE && !supply_valid_i
      |=> state_reg inside {pss_pkg::ST_BACKUP, pss_pkg::ST_OFF} ##1 rail_enable_out_o == '0;
  endproperty
  a_emergency: assert property (p_emergency) else $error("emergency power-down wrong");
  property p_no_backup;
    supply_lost && !cfg_loaded_reg |=> state_reg == pss_pkg::ST_OFF;
  endproperty
  a_no_backup: assert property (p_no_backup) else $error("backup without config");
  property p_ready;
    state_reg == pss_pkg::ST_SELFTEST |-> tmr_reg < READY_T;
  endproperty
  a_ready: assert property (p_ready) else $error("self-test overran");
  property p_osc;
    clk_run && per_reg == OSC_MAX |=> fault_status_o[pss_pkg::FLT_OSC];
  endproperty
  a_osc: assert property (p_osc) else $error("clock fault missed");
  property p_clk_start;
    up_reg == TMR_W'(CLK_START_CYC) && state_reg != pss_pkg::ST_FAILSAFE |-> clk_run;
  endproperty
  a_clk_start: assert property (p_clk_start) else $error("clock late");
  property p_act_start;
    state_reg == pss_pkg::ST_SHUTDOWN_STATE_ONE && supply_valid_i && !button_enable_i && active_request_in_i
      |=> state_reg == pss_pkg::ST_PWRUP ##1 rail_enable_out_o
      == rails_upto(powerup_slot_select_i, FIRST_SLOT);
  endproperty
  a_act_start: assert property (p_act_start) else $error("power-up not started");
endmodule

/* File: pss_far.sv */
// far side model: self-test engine, otp array and crystal
// assumes test_i is high while the sequencer sits in self-test
`timescale 1ns/1ps
module pss_far (
  input wire logic clk_i,
  input wire logic test_i,
  input wire logic fail_mode_i,
  input wire logic [7:0] data_i,
  input wire logic hold_i,
  input wire logic ded_i,
  output logic done_o,
  output logic fail_o,
  output logic [12:0] otp_o,
  output logic xtal_o
);
  // ****************
  // engine and crystal
  // ****************
  logic [7:0] tcnt;
  logic [7:0] xcnt;
  logic [12:0] w;
  int i;
  int k;
  initial begin
    tcnt = 8'h00;
    xcnt = 8'h00;
    xtal_o = 1'h0;
  end
  always @(posedge clk_i) begin
    tcnt <= test_i ? tcnt + 8'h01 : 8'h00;
  end
  // half period of 152 cycles keeps the period inside the monitor window
  // hold freezes the crystal to provoke the oscillator fault
  always @(posedge clk_i) begin
    if (hold_i) begin
      xcnt <= xcnt;
    end else if (xcnt == 8'h97) begin
      xcnt <= 8'h00;
      xtal_o <= ~xtal_o;
    end else begin
      xcnt <= xcnt + 8'h01;
    end
  end
  assign done_o = tcnt > 8'h14;
  assign fail_o = fail_mode_i && tcnt > 8'h0a;
  always_comb begin
    w = 13'h0000;
    k = 0;
    for (i = 1; i < 13; i++) begin
      if (i != 1 && i != 2 && i != 4 && i != 8) begin
        w[i] = data_i[k];
        k++;
      end
    end
    for (i = 3; i < 13; i++) begin
      if (i[0]) w[1] ^= w[i];
      if (i[1]) w[2] ^= w[i];
      if (i[2]) w[4] ^= w[i];
      if (i[3]) w[8] ^= w[i];
    end
    w[0] = ^w[12:1];
  end
  // one flipped bit exercises the correction path
  // a second flipped bit makes an uncorrectable word
  assign otp_o = w ^ (ded_i ? 13'h0060 : 13'h0020);
endmodule

/* File: tb.sv */
// self-checking bench of the power state sequencer
// assumes pss_top and the far side model pss_far
`timescale 1ns/1ps
module tb;
  // ****************
  // bench
  // ****************
  logic mclk_i, resetn_i, sup, bat, act, sn, grd, fm, tpor;
  logic btn, ben, tsh, hold, ded, g2;
  logic [1:0] fld;
  logic [2:0] fclr, flt;
  logic [3:0] dly;
  logic [47:0] slots;
  logic done, fail, xtal, rst_n, irq_n, rclk, i2c, ecc, g1;
  logic [12:0] otp;
  logic [11:0] rails;
  logic [7:0] cfg;
  logic [3:0] st;
  int error_cnt, compares;
  localparam logic [7:0] CFG = 8'h5a;
  localparam logic [11:0] SLP = 12'h0f0;
  initial begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end
  pss_far i_far (.clk_i(mclk_i), .test_i(st === 4'h1), .fail_mode_i(fm), .data_i(CFG),
    .hold_i(hold), .ded_i(ded),
    .done_o(done), .fail_o(fail), .otp_o(otp), .xtal_o(xtal));
  pss_top #(.READY_CYC(200), .CLK_START_CYC(400), .SLOT_CYC(4), .RST_UNIT_CYC(3)) i_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .supply_valid_i(sup), .battery_supply_ok_i(bat),
    .selftest_done_i(done), .selftest_fail_i(fail), .selftest_on_poweron_i(tpor),
    .selftest_on_shutdown_exit_i(tsh), .otp_word_i(otp), .active_request_in_i(act),
    .sleep_request_n_i(sn), .power_button_in_n_i(btn), .button_enable_i(ben),
    .soft_shutdown_field_i(fld), .reset_release_delay_i(dly), .powerup_slot_select_i(slots),
    .sleep_assign_i(SLP), .xtal_i(xtal), .fault_clear_i(fclr), .write_guard_one_set_i(grd),
    .write_guard_two_set_i(grd), .rail_enable_out_o(rails), .system_reset_out_n_o(rst_n),
    .interrupt_out_n_o(irq_n), .rtc_clock_out_o(rclk), .i2c_active_o(i2c),
    .config_data_o(cfg), .ecc_corrected_o(ecc), .fault_status_o(flt), .rtc_time_o(),
    .write_guard_one_o(g1), .write_guard_two_o(g2), .power_state_o(st));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic print_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_st(input logic [3:0] s, output int n);
    for (n = 0; n < 3000 && st !== s; n++) cyc(1);
    if (n == 3000) begin
      error_cnt++;
      $display("CHECK FAILED state exp %h seen %h", s, st);
      print_verdict;
    end
  endtask
  task automatic boot(input logic f);
    int n;
    fm = f;
    sup = 1'h1;
    wait_st(4'h1, n);
    cyc(2);
    chk("test_outs", 32'h4, {rails, rst_n, irq_n, rclk, i2c});
  endtask
  task automatic sc_pass;
    int n;
    boot(1'h0);
    wait_st(4'h3, n);
    cyc(2);
    chk("i2c", 1'h1, i2c);
    chk("cfg", CFG, cfg);
    chk("ecc", 1'h1, ecc);
    chk("no_flt", 3'h0, flt);
    for (n = 0; n < 400 && rclk !== 1'h1; n++) cyc(1);
    chk("clk_start", 1'h1, rclk);
  endtask
  task automatic sc_up;
    int n;
    act = 1'h1;
    wait_st(4'h6, n);
    wait_st(4'h7, n);
    chk("rst_wait", 32'(dly) * 3 + 1, n);
    cyc(2);
    chk("up", 32'h1fff, {rails, rst_n});
    sn = 1'h0;
    wait_st(4'h8, n);
    cyc(2);
    chk("rails_sleep", SLP ^ 12'hfff, rails);
    sn = 1'h1;
    wait_st(4'h7, n);
    cyc(2);
    chk("rails_wake", 12'hfff, rails);
  endtask
  task automatic sc_backup;
    int n;
    grd = 1'h1;
    cyc(1);
    grd = 1'h0;
    cyc(1);
    chk("guard_set", 2'h3, {g1, g2});
    sup = 1'h0;
    wait_st(4'ha, n);
    cyc(2);
    chk("bk_outs", 32'h0, {rails, rst_n, rclk, g1, g2});
    act = 1'h0;
    sup = 1'h1;
    cyc(1);
    chk("bk_exit", 4'h3, st);
  endtask
  task automatic sc_osc;
    hold = 1'h1;
    cyc(340);
    chk("osc_fault", 4'h8, {flt, irq_n});
    hold = 1'h0;
    cyc(320);
    fclr = 3'h4;
    cyc(1);
    fclr = 3'h0;
    cyc(2);
    chk("osc_clear", 4'h1, {flt, irq_n});
  endtask
  task automatic sc_soft;
    int n;
    act = 1'h1;
    wait_st(4'h7, n);
    ben = 1'h1;
    tsh = 1'h1;
    fld = 2'h1;
    wait_st(4'h9, n);
    fld = 2'h0;
    wait_st(4'h4, n);
    cyc(5);
    chk("shutdown_state_two_hold", 4'h4, st);
    btn = 1'h0;
    cyc(1);
    btn = 1'h1;
    chk("btn_start", 4'h5, st);
    wait_st(4'h7, n);
    ben = 1'h0;
    act = 1'h0;
    wait_st(4'h1, n);
    wait_st(4'h3, n);
    tsh = 1'h0;
    ben = 1'h1;
    cyc(1);
    chk("auto_start", 4'h5, st);
    wait_st(4'h7, n);
  endtask
  task automatic do_reset;
    resetn_i = 1'h0;
    sup = 1'h0;
    cyc(20);
    resetn_i = 1'h1;
    cyc(1);
  endtask
  task automatic sc_fail;
    int n;
    do_reset;
    boot(1'h1);
    wait_st(4'hb, n);
    act = 1'h1;
    cyc(3);
    chk("fs_outs", 32'h0, {rails, rclk, rst_n, irq_n});
    chk("fs_hold", 4'hb, st);
    sup = 1'h0;
    cyc(2);
    chk("fs_exit", 4'h0, st);
  endtask
  task automatic sc_ded;
    int n;
    do_reset;
    ded = 1'h1;
    tpor = 1'h0;
    sup = 1'h1;
    wait_st(4'hb, n);
    cyc(2);
    chk("ded_flt", 4'h4, {flt, irq_n});
    sup = 1'h0;
    cyc(2);
    chk("ded_exit", 4'h0, st);
  endtask
  initial begin
    resetn_i = 1'h0;
    sup = 1'h0;
    bat = 1'h1;
    act = 1'h0;
    sn = 1'h1;
    grd = 1'h0;
    fm = 1'h0;
    tpor = 1'h1;
    btn = 1'h1;
    ben = 1'h0;
    tsh = 1'h0;
    hold = 1'h0;
    ded = 1'h0;
    fld = 2'h0;
    fclr = 3'h0;
    dly = 4'h2;
    error_cnt = 0;
    compares = 0;
    for (int r = 0; r < 12; r++) slots[4*r +: 4] = 4'(r + 1);
    cyc(20);
    chk("reset_vals", 32'h2, {st, rails, rst_n, irq_n, i2c});
    resetn_i = 1'h1;
    cyc(1);
    sc_pass;
    sc_up;
    sc_backup;
    sc_osc;
    sc_soft;
    sc_fail;
    sc_ded;
    print_verdict;
  end
endmodule
